/* File: core/sebl_pkg.sv */
// constants shared by the serial eeprom auto-boot loader
`default_nettype none
package sebl_pkg;
	// ----------------------------------------------------------------
	// link framing
	// ----------------------------------------------------------------
	localparam logic [7:0]  READ_OPCODE    = 8'h03;
	localparam logic [7:0]  START_ADDR     = 8'h00;
	localparam int          HDR_BITS       = 16;
	localparam int          BYTE_BITS      = 8;
	localparam logic [3:0]  HDR_LAST_BIT   = 4'hf;
	localparam logic [3:0]  BYTE_LAST_BIT  = 4'h7;

	// ----------------------------------------------------------------
	// boot stream decoding
	// ----------------------------------------------------------------
	localparam logic [1:0]  WR_CMD_MARK    = 2'h1;
	localparam int          WR_CMD_MSB     = 7;
	localparam int          WR_ADDR_MSB    = 5;
	localparam int          WR_ADDR_LSB    = 1;
	localparam logic [1:0]  WR_LAST_BYTE   = 2'h2;
	localparam logic [4:0]  ADDR_OPMODE    = 5'h12;
	localparam logic [4:0]  ADDR_IGAIN     = 5'h02;
	localparam logic [4:0]  ADDR_VGAIN     = 5'h04;
	localparam logic [4:0]  ADDR_MASK      = 5'h1a;
	localparam logic [4:0]  ADDR_CONTROL   = 5'h1c;
	localparam int          STOP_BIT_POS   = 8;
	localparam logic [7:0]  CMD_START_CONV = 8'he8;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_PS  = 4000;
	localparam int          LINK_PERIOD_PS = 6000;
	localparam int          SCLK_HALF_NS   = 500;
	localparam int          SCLK_HALF_CYC  =
		(SCLK_HALF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
	localparam logic [6:0]  SCLK_HALF_LAST = 7'(SCLK_HALF_CYC - 1);
	localparam logic [1:0]  MODE_SETTLE    = 2'h3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] TX_RESET       = 16'h0000;
	localparam logic [7:0]  BYTE_RESET     = 8'h00;
	localparam logic [23:0] DATA_RESET     = 24'h000000;
endpackage : sebl_pkg
`default_nettype wire

/* File: core/sebl_buf.sv */
// two-entry byte buffer with valid/ready on both sides
`default_nettype none
module sebl_buf (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       in_valid,
	output logic            in_ready,
	input  wire logic [7:0] in_data,
	output logic            out_valid,
	input  wire logic       out_ready,
	output logic [7:0]      out_data
);
	logic [7:0] slot0;
	logic [7:0] slot1;
	logic [1:0] fill;
	logic [7:0] next_slot0;
	logic [7:0] next_slot1;
	logic [1:0] next_fill;
	logic       push;
	logic       pop;

	// slot0 is always the head, so read data come straight from a register
	always_comb begin
		push       = in_valid && (fill != 2'h2);
		pop        = out_ready && (fill != 2'h0);
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_fill  = fill;
		if (pop && push) begin
			next_slot0 = (fill == 2'h1) ? in_data : slot1;
			next_slot1 = in_data;
		end else if (pop) begin
			next_slot0 = slot1;
			next_fill  = fill - 2'h1;
		end else if (push) begin
			if (fill == 2'h0) begin
				next_slot0 = in_data;
			end else begin
				next_slot1 = in_data;
			end
			next_fill = fill + 2'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			slot0 <= sebl_pkg::BYTE_RESET;
			slot1 <= sebl_pkg::BYTE_RESET;
			fill  <= 2'h0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			fill  <= next_fill;
		end
	end

	assign in_ready  = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data  = slot0;
endmodule : sebl_buf
`default_nettype wire

/* File: core/sebl_loader.sv */
// auto-boot loader: eeprom link master and boot stream executor
`default_nettype none
module sebl_loader (
	input  wire logic        CLK,
	input  wire logic        ARST_N,
	input  wire logic        LINK_CLK,
	input  wire logic        MODE_PIN,
	output logic             CS_N,
	output logic             CS_N_OE,
	output logic             SCLK,
	output logic             SCLK_OE,
	output logic             SERIAL_OUT_PIN,
	output logic             SERIAL_OUT_OE,
	input  wire logic        SERIAL_IN_PIN,
	output logic             OUT_VALID,
	input  wire logic        OUT_READY,
	output logic             OUT_WRITE,
	output logic [7:0]       OUT_CODE,
	output logic [23:0]      OUT_DATA,
	output logic             BOOT_BUSY,
	output logic             BOOT_DONE
);
	typedef enum logic [2:0] {L_IDLE, L_LEAD, L_HDR, L_READ, L_WAIT, L_END} sebl_link_t;
	typedef enum logic [1:0] {C_SETTLE, C_HOST, C_BOOT, C_DONE} sebl_core_t;
	typedef enum logic [1:0] {E_CMD, E_DATA, E_OUT} sebl_exec_t;

	// ----------------------------------------------------------------
	// link-domain reset and synchronisers
	// ----------------------------------------------------------------
	logic       lrst_a;
	logic       lrst_n;
	logic       boot_a;
	logic       boot_s;
	logic       stop_a;
	logic       stop_s;
	logic       ack_a;
	logic       ack_s;
	logic       sin_a;
	logic       sin_s;

	// release is synchronised so the link state leaves reset cleanly
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lrst_a <= 1'b0;
			lrst_n <= 1'b0;
		end else begin
			lrst_a <= 1'b1;
			lrst_n <= lrst_a;
		end
	end

	logic boot_req;
	logic stop_req;
	logic ack_tgl;

	always_ff @(posedge LINK_CLK or negedge lrst_n) begin
		if (!lrst_n) begin
			boot_a <= 1'b0;
			boot_s <= 1'b0;
			stop_a <= 1'b0;
			stop_s <= 1'b0;
			ack_a  <= 1'b0;
			ack_s  <= 1'b0;
			sin_a  <= 1'b0;
			sin_s  <= 1'b0;
		end else begin
			boot_a <= boot_req;
			boot_s <= boot_a;
			stop_a <= stop_req;
			stop_s <= stop_a;
			ack_a  <= ack_tgl;
			ack_s  <= ack_a;
			sin_a  <= SERIAL_IN_PIN;
			sin_s  <= sin_a;
		end
	end

	// ----------------------------------------------------------------
	// link master
	// ----------------------------------------------------------------
	sebl_link_t  lst;
	sebl_link_t  next_lst;
	logic [6:0]  ph;
	logic [6:0]  next_ph;
	logic [3:0]  bitn;
	logic [3:0]  next_bitn;
	logic [15:0] tx;
	logic [15:0] next_tx;
	logic [7:0]  rx;
	logic [7:0]  next_rx;
	logic        byte_tgl;
	logic        next_byte_tgl;
	logic        sclk_q;
	logic        next_sclk;
	logic        cs_n_q;
	logic        next_cs_n;
	logic        oe_q;
	logic        next_oe;
	logic        half_end;

	always_comb begin
		half_end      = (ph == sebl_pkg::SCLK_HALF_LAST);
		next_lst      = lst;
		next_ph       = half_end ? 7'h00 : ph + 7'h01;
		next_bitn     = bitn;
		next_tx       = tx;
		next_rx       = rx;
		next_byte_tgl = byte_tgl;
		next_sclk     = sclk_q;
		next_cs_n     = cs_n_q;
		next_oe       = oe_q;
		case (lst)
			L_IDLE: begin
				next_ph = 7'h00;
				if (boot_s) begin
					next_lst  = L_LEAD;
					next_cs_n = 1'b0;
					next_oe   = 1'b1;
					next_tx   = {sebl_pkg::READ_OPCODE, sebl_pkg::START_ADDR};
					next_bitn = 4'h0;
				end
			end
			L_LEAD: begin
				if (half_end) begin
					next_lst = L_HDR;
				end
			end
			L_HDR: begin
				if (half_end) begin
					next_sclk = !sclk_q;
					if (sclk_q) begin
						next_tx   = {tx[14:0], 1'b0};
						next_bitn = bitn + 4'h1;
						if (bitn == sebl_pkg::HDR_LAST_BIT) begin
							next_lst  = L_READ;
							next_bitn = 4'h0;
						end
					end
				end
			end
			L_READ: begin
				if (half_end) begin
					next_sclk = !sclk_q;
					if (sclk_q) begin
						// data settled during the low phase, well past the synchroniser
						next_rx   = {rx[6:0], sin_s};
						next_bitn = bitn + 4'h1;
						if (bitn == sebl_pkg::BYTE_LAST_BIT) begin
							next_lst      = L_WAIT;
							next_byte_tgl = !byte_tgl;
						end
					end
				end
			end
			L_WAIT: begin
				// clock parked low until the core has taken the byte
				next_ph = 7'h00;
				if (ack_s == byte_tgl) begin
					next_lst  = L_READ;
					next_bitn = 4'h0;
				end
			end
			L_END: begin
				next_ph = 7'h00;
			end
			default: begin
				next_lst = L_IDLE;
			end
		endcase
		if (stop_s && (lst != L_IDLE) && (lst != L_END)) begin
			next_lst  = L_END;
			next_cs_n = 1'b1;
			next_sclk = 1'b0;
			next_oe   = 1'b0;
			next_tx   = sebl_pkg::TX_RESET;
		end
	end

	always_ff @(posedge LINK_CLK or negedge lrst_n) begin
		if (!lrst_n) begin
			lst      <= L_IDLE;
			ph       <= 7'h00;
			bitn     <= 4'h0;
			tx       <= sebl_pkg::TX_RESET;
			rx       <= sebl_pkg::BYTE_RESET;
			byte_tgl <= 1'b0;
			sclk_q   <= 1'b0;
			cs_n_q   <= 1'b1;
			oe_q     <= 1'b0;
		end else begin
			lst      <= next_lst;
			ph       <= next_ph;
			bitn     <= next_bitn;
			tx       <= next_tx;
			rx       <= next_rx;
			byte_tgl <= next_byte_tgl;
			sclk_q   <= next_sclk;
			cs_n_q   <= next_cs_n;
			oe_q     <= next_oe;
		end
	end

	assign CS_N           = cs_n_q;
	assign CS_N_OE        = oe_q;
	assign SCLK           = sclk_q;
	assign SCLK_OE        = oe_q;
	assign SERIAL_OUT_PIN = tx[15];
	assign SERIAL_OUT_OE  = oe_q;

	// ----------------------------------------------------------------
	// core-domain synchronisers
	// ----------------------------------------------------------------
	logic mode_a;
	logic mode_s;
	logic tgl_a;
	logic tgl_s;

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_a <= 1'b0;
			mode_s <= 1'b0;
			tgl_a  <= 1'b0;
			tgl_s  <= 1'b0;
		end else begin
			mode_a <= MODE_PIN;
			mode_s <= mode_a;
			tgl_a  <= byte_tgl;
			tgl_s  <= tgl_a;
		end
	end

	// ----------------------------------------------------------------
	// byte crossing into the buffer
	// ----------------------------------------------------------------
	logic       buf_in_valid;
	logic       buf_in_ready;
	logic       buf_out_valid;
	logic       buf_out_ready;
	logic [7:0] buf_out_data;
	sebl_core_t cst;

	// rx is frozen while the toggle is unacknowledged, so it is safe to sample
	assign buf_in_valid = (cst == C_BOOT) && (tgl_s != ack_tgl);

	sebl_buf u_buf (
		.clk       (CLK),
		.arst_n    (ARST_N),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (rx),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	// ----------------------------------------------------------------
	// boot control and stream executor
	// ----------------------------------------------------------------
	sebl_core_t  next_cst;
	sebl_exec_t  est;
	sebl_exec_t  next_est;
	logic [1:0]  settle;
	logic [1:0]  next_settle;
	logic [1:0]  bcnt;
	logic [1:0]  next_bcnt;
	logic        next_ack_tgl;
	logic        next_boot_req;
	logic        next_stop_req;
	logic [7:0]  code;
	logic [7:0]  next_code;
	logic [23:0] data;
	logic [23:0] next_data;
	logic        out_valid;
	logic        next_out_valid;
	logic        out_write;
	logic        next_out_write;
	logic        busy;
	logic        next_busy;
	logic        done;
	logic        next_done;
	logic        pop;
	logic        is_wr;

	always_comb begin
		buf_out_ready  = (cst == C_DONE) || ((cst == C_BOOT) && (est != E_OUT));
		pop            = buf_out_ready && buf_out_valid;
		is_wr          = (buf_out_data[sebl_pkg::WR_CMD_MSB -: 2] == sebl_pkg::WR_CMD_MARK);
		next_cst       = cst;
		next_est       = est;
		next_settle    = settle;
		next_bcnt      = bcnt;
		next_ack_tgl   = ack_tgl;
		next_boot_req  = boot_req;
		next_stop_req  = stop_req;
		next_code      = code;
		next_data      = data;
		next_out_valid = out_valid;
		next_out_write = out_write;
		if (buf_in_valid && buf_in_ready) begin
			next_ack_tgl = !ack_tgl;
		end
		case (cst)
			C_SETTLE: begin
				// mode is read only after the synchroniser has filled
				next_settle = settle + 2'h1;
				if (settle == sebl_pkg::MODE_SETTLE) begin
					next_cst      = mode_s ? C_BOOT : C_HOST;
					next_boot_req = mode_s;
				end
			end
			C_HOST: begin
			end
			C_BOOT: begin
				case (est)
					E_CMD: begin
						if (pop) begin
							next_code = buf_out_data;
							next_data = sebl_pkg::DATA_RESET;
							next_bcnt = 2'h0;
							if (is_wr) begin
								next_est = E_DATA;
							end else begin
								next_est       = E_OUT;
								next_out_valid = 1'b1;
								next_out_write = 1'b0;
							end
						end
					end
					E_DATA: begin
						if (pop) begin
							next_data = {data[15:0], buf_out_data};
							next_bcnt = bcnt + 2'h1;
							if (bcnt == sebl_pkg::WR_LAST_BYTE) begin
								next_est       = E_OUT;
								next_out_valid = 1'b1;
								next_out_write = 1'b1;
							end
						end
					end
					E_OUT: begin
						if (OUT_READY) begin
							next_out_valid = 1'b0;
							next_est       = E_CMD;
							if (out_write
								&& (code[sebl_pkg::WR_ADDR_MSB:sebl_pkg::WR_ADDR_LSB]
									== sebl_pkg::ADDR_CONTROL)
								&& data[sebl_pkg::STOP_BIT_POS]) begin
								next_cst      = C_DONE;
								next_stop_req = 1'b1;
							end
						end
					end
					default: begin
						next_est = E_CMD;
					end
				endcase
			end
			C_DONE: begin
			end
			default: begin
				next_cst = C_SETTLE;
			end
		endcase
		next_busy = (next_cst == C_BOOT);
		next_done = (next_cst == C_DONE);
	end

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cst       <= C_SETTLE;
			est       <= E_CMD;
			settle    <= 2'h0;
			bcnt      <= 2'h0;
			ack_tgl   <= 1'b0;
			boot_req  <= 1'b0;
			stop_req  <= 1'b0;
			code      <= sebl_pkg::BYTE_RESET;
			data      <= sebl_pkg::DATA_RESET;
			out_valid <= 1'b0;
			out_write <= 1'b0;
			busy      <= 1'b0;
			done      <= 1'b0;
		end else begin
			cst       <= next_cst;
			est       <= next_est;
			settle    <= next_settle;
			bcnt      <= next_bcnt;
			ack_tgl   <= next_ack_tgl;
			boot_req  <= next_boot_req;
			stop_req  <= next_stop_req;
			code      <= next_code;
			data      <= next_data;
			out_valid <= next_out_valid;
			out_write <= next_out_write;
			busy      <= next_busy;
			done      <= next_done;
		end
	end

	assign OUT_VALID = out_valid;
	assign OUT_WRITE = out_write;
	assign OUT_CODE  = code;
	assign OUT_DATA  = data;
	assign BOOT_BUSY = busy;
	assign BOOT_DONE = done;
endmodule : sebl_loader
`default_nettype wire

/* File: dv/sebl_loader_sva.sv */
// assertion checker for the auto-boot loader ports
`default_nettype none
module sebl_loader_chk (
	input wire logic        CLK,
	input wire logic        ARST_N,
	input wire logic        LINK_CLK,
	input wire logic        CS_N,
	input wire logic        CS_N_OE,
	input wire logic        SCLK,
	input wire logic        SCLK_OE,
	input wire logic        SERIAL_OUT_PIN,
	input wire logic        SERIAL_OUT_OE,
	input wire logic        OUT_VALID,
	input wire logic        OUT_READY,
	input wire logic        OUT_WRITE,
	input wire logic [7:0]  OUT_CODE,
	input wire logic [23:0] OUT_DATA,
	input wire logic        BOOT_BUSY,
	input wire logic        BOOT_DONE
);
	timeunit 1ns;
	timeprecision 100ps;
	// ------------
	// link checks
	// ------------
	logic [7:0] hi_cnt;
	logic [7:0] next_hi_cnt;
	always_comb next_hi_cnt = SCLK ? hi_cnt + 8'h01 : 8'h00;
	always_ff @(posedge LINK_CLK or negedge ARST_N) begin
		if (!ARST_N) hi_cnt <= 8'h00;
		else hi_cnt <= next_hi_cnt;
	end
	chk_pins_drive: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		CS_N_OE |-> !CS_N && SCLK_OE && SERIAL_OUT_OE) else $error("pins not driven");
	chk_pins_park: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		!CS_N_OE |-> !SCLK && !SERIAL_OUT_PIN) else $error("released pins not parked");
	chk_sclk_high: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		$fell(SCLK) && CS_N_OE |-> hi_cnt == 8'(sebl_pkg::SCLK_HALF_CYC))
		else $error("sclk high phase length wrong");
	// lead-in half plus the first low half of the header: two halves before the first rise
	chk_first_rise: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		$fell(CS_N) |-> ##168 $rose(SCLK)) else $error("first sclk rise late or early");
	chk_sdo_fall: assert property (@(posedge LINK_CLK) disable iff (!ARST_N)
		CS_N_OE && $past(CS_N_OE) && $changed(SERIAL_OUT_PIN) |-> $fell(SCLK))
		else $error("data out changed off falling edge");
	// ------------
	// stream checks
	// ------------
	chk_item_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_CODE)
		&& $stable(OUT_DATA) && $stable(OUT_WRITE)) else $error("item not held");
	chk_item_gap: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_VALID && OUT_READY |=> !OUT_VALID) else $error("valid stayed after handshake");
	chk_write_kind: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_VALID |-> OUT_WRITE == (OUT_CODE[7:6] == sebl_pkg::WR_CMD_MARK))
		else $error("write flag disagrees with code");
	chk_cmd_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_VALID && !OUT_WRITE |-> OUT_DATA == 24'h000000) else $error("command data not zero");
	chk_stop_done: assert property (@(posedge CLK) disable iff (!ARST_N)
		OUT_VALID && OUT_READY && OUT_WRITE && OUT_DATA[8]
		&& OUT_CODE[5:1] == sebl_pkg::ADDR_CONTROL |=> BOOT_DONE && !BOOT_BUSY)
		else $error("stop write did not end boot");
	chk_done_hold: assert property (@(posedge CLK) disable iff (!ARST_N)
		BOOT_DONE |=> BOOT_DONE && !OUT_VALID) else $error("item after boot end");
	cov_stall: cover property (@(posedge CLK) OUT_VALID && !OUT_READY);
	cov_take: cover property (@(posedge CLK) OUT_VALID && OUT_READY && !OUT_WRITE);
	cov_done: cover property (@(posedge CLK) $rose(BOOT_DONE));
endmodule : sebl_loader_chk
bind sebl_loader sebl_loader_chk u_chk (.CLK, .ARST_N, .LINK_CLK, .CS_N, .CS_N_OE, .SCLK,
	.SCLK_OE, .SERIAL_OUT_PIN, .SERIAL_OUT_OE, .OUT_VALID, .OUT_READY, .OUT_WRITE,
	.OUT_CODE, .OUT_DATA, .BOOT_BUSY, .BOOT_DONE);
`default_nettype wire

/* File: dv/sebl_eeprom.sv */
// behavioural serial eeprom answering the loader's read
`default_nettype none
module sebl_eeprom (
	input  wire logic cs_n,
	input  wire logic sclk,
	input  wire logic mosi,
	output var logic  miso
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0]  mem [0:31];
	logic [15:0] hdr;
	int          rises;
	int          bitn;
	int          dly;
	logic        b;
	initial begin
		miso = 1'b0;
		hdr = 16'h0000;
		dly = 0;
		foreach (mem[i]) mem[i] = 8'h00;
	end
	always @(negedge cs_n) begin
		rises = 0;
		bitn = 0;
	end
	// line not driven during the header, so it wobbles
	always @(posedge sclk) begin
		if (!cs_n && rises < 16) begin
			hdr = {hdr[14:0], mosi};
			rises++;
			miso = ~miso;
		end
	end
	// wrong opcode gets garbage, not data
	always @(negedge sclk) begin
		if (!cs_n && rises == 16) begin
			b = (hdr[15:8] == 8'h03) ? mem[5'(hdr[7:0] + bitn / 8)][7 - bitn % 8] : ~miso;
			bitn++;
			#(dly) miso = b;
		end
	end
	always @(posedge cs_n) miso = ~miso;
endmodule : sebl_eeprom
`default_nettype wire

/* File: dv/sebl_loader_tb_top.sv */
// self-checking bench for the auto-boot loader
`default_nettype none
module sebl_loader_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic        w;
		logic [7:0]  c;
		logic [23:0] d;
		logic [15:0] stall;
	} sebl_row_t;
	logic        CLK = 1'b0;
	logic        LINK_CLK = 1'b0;
	logic        ARST_N = 1'b0;
	logic        MODE_PIN = 1'b0;
	logic        OUT_READY = 1'b0;
	logic        CS_N, CS_N_OE, SCLK, SCLK_OE, SERIAL_OUT_PIN, SERIAL_OUT_OE;
	logic        SERIAL_IN_PIN, OUT_VALID, OUT_WRITE, BOOT_BUSY, BOOT_DONE;
	logic [7:0]  OUT_CODE;
	logic [23:0] OUT_DATA;
	int          n_fail = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	sebl_row_t   rows [6] = '{
		'{1'b1, 8'h64, 24'h000060, 16'h0000},
		'{1'b1, 8'h44, 24'h7fc4a9, 16'h2ee0},
		'{1'b1, 8'h48, 24'hffb253, 16'h0000},
		'{1'b1, 8'h74, 24'h000004, 16'h0000},
		'{1'b0, 8'he8, 24'h000000, 16'h0000},
		'{1'b1, 8'h78, 24'h000100, 16'h0000}};
	// pull-up on chip select, pull-down on clock and data
	wire logic   cs_lvl = CS_N_OE ? CS_N : 1'b1;
	wire logic   sck_lvl = SCLK_OE ? SCLK : 1'b0;
	wire logic   mo_lvl = SERIAL_OUT_OE ? SERIAL_OUT_PIN : 1'b0;
	sebl_loader u_sebl_loader (.CLK, .ARST_N, .LINK_CLK, .MODE_PIN, .CS_N, .CS_N_OE, .SCLK,
		.SCLK_OE, .SERIAL_OUT_PIN, .SERIAL_OUT_OE, .SERIAL_IN_PIN, .OUT_VALID, .OUT_READY,
		.OUT_WRITE, .OUT_CODE, .OUT_DATA, .BOOT_BUSY, .BOOT_DONE);
	sebl_eeprom u_sebl_eeprom (.cs_n(cs_lvl), .sclk(sck_lvl), .mosi(mo_lvl),
		.miso(SERIAL_IN_PIN));
	always #2 CLK = ~CLK;
	initial begin
		#1.3;
		forever #3 LINK_CLK = ~LINK_CLK;
	end
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 95000) begin
			n_fail++;
			end_of_test();
		end
	end
	task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic rst(input logic mode);
		ARST_N = 1'b0;
		MODE_PIN = mode;
		repeat (20) @(negedge CLK);
		chk("reset pins", 24'h4, 24'({CS_N, CS_N_OE, OUT_VALID}));
		ARST_N = 1'b1;
	endtask : rst
	task automatic load(input int i0, input int i1, input int a0);
		int a;
		a = a0;
		for (int i = i0; i <= i1; i++) begin
			u_sebl_eeprom.mem[a] = rows[i].c;
			if (rows[i].w) {u_sebl_eeprom.mem[a + 1], u_sebl_eeprom.mem[a + 2],
				u_sebl_eeprom.mem[a + 3]} = rows[i].d;
			a += rows[i].w ? 4 : 1;
		end
	endtask : load
	// a long stall fills the buffer, so the link must park
	task automatic take(input sebl_row_t r);
		int n;
		n = 0;
		while (OUT_VALID !== 1'b1 && n < 20000) begin
			@(negedge CLK);
			n++;
		end
		chk("write", 24'(r.w), 24'(OUT_WRITE));
		chk("code", 24'(r.c), 24'(OUT_CODE));
		chk("data", r.d, OUT_DATA);
		repeat (r.stall) @(negedge CLK);
		if (r.stall != 16'h0000) chk("parked sclk", 24'h0, 24'(SCLK));
		OUT_READY = 1'b1;
		@(negedge CLK);
		OUT_READY = 1'b0;
		$display("item %h done", r.c);
	endtask : take
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_of_test
	initial begin
		rst(1'b0);
		repeat (500) @(negedge CLK);
		chk("host idle", 24'h0, 24'({BOOT_BUSY, CS_N_OE, SCLK_OE, SERIAL_OUT_OE}));
		$display("host mode test done");
		rst(1'b1);
		load(0, 5, 0);
		repeat (10) @(negedge CLK);
		chk("boot busy", 24'h1, 24'(BOOT_BUSY));
		for (int i = 0; i < 6; i++) begin
			take(rows[i]);
		end
		chk("header", 24'h000300, 24'(u_sebl_eeprom.hdr));
		@(negedge CLK);
		chk("done flags", 24'h1, 24'({BOOT_BUSY, BOOT_DONE}));
		repeat (100) @(negedge CLK);
		chk("released", 24'h4, 24'({CS_N, CS_N_OE, SCLK_OE}));
		$display("full boot test done");
		// stop first, a write behind it must be ignored, eeprom answers late
		rst(1'b1);
		load(5, 5, 0);
		load(0, 0, 4);
		u_sebl_eeprom.dly = 300;
		take(rows[5]);
		repeat (3000) @(negedge CLK);
		chk("after stop", 24'h9, 24'({CS_N, CS_N_OE, OUT_VALID, BOOT_DONE}));
		$display("early stop test done");
		end_of_test();
	end
endmodule : sebl_loader_tb_top
`default_nettype wire
